/* core/pmev_params.svh */
`ifndef PMEV_PARAMS_SVH
`define PMEV_PARAMS_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define PMEV_IDX_IDATA_HI 10'h0D2
`define PMEV_IDX_PWR_CTRL 10'h0D4
`define PMEV_IDX_INT_STAT 10'h0E0
`define PMEV_IDX_INT_MASK 10'h0E1
`define PMEV_ADDR(i) ({(i), 2'b00})

// =====================================================================
// power_event_control field positions
`define PMEV_BIT_DLY_EN 14
`define PMEV_BIT_RSVD13 13
`define PMEV_BIT_POL 12
`define PMEV_LSB_WOL_EN 8
`define PMEV_BIT_AUTO_WAKE 7
`define PMEV_BIT_WAKE_NORM 6
`define PMEV_LSB_WAKE_STAT 2
`define PMEV_LSB_MODE 0

// =====================================================================
// reset values
`define PMEV_RST_IDATA_HI 16'h0000
`define PMEV_RST_WOL_EN 4'h0
`define PMEV_RST_MODE 2'h0
`define PMEV_RST_INT_MASK 4'h0

`endif

/* core/pmev_pkg.sv */
package pmev_pkg;

  // one bit for each wake-on-LAN event, top bit first
  typedef struct packed {
    logic frame;
    logic magic;
    logic link_up;
    logic energy;
  } pmev_wake_t;

  typedef enum logic [1:0] {
    PMEV_MODE_NORMAL = 2'h0,
    PMEV_MODE_ENERGY = 2'h1,
    PMEV_MODE_SOFT_PD = 2'h2,
    PMEV_MODE_RSVD = 2'h3
  } pmev_mode_t;

  typedef struct packed {
    logic dly_en;
    logic rsvd13;
    logic pol;
    pmev_wake_t wol_en;
    logic auto_wake;
    logic wake_norm;
    pmev_mode_t mode;
  } pmev_ctrl_t;

  typedef enum logic [1:0] {
    PMEV_PS_NORMAL = 2'b01,
    PMEV_PS_LOW = 2'b10
  } pmev_pstate_t;

endpackage

/* core/pmev_sticky.sv */
`timescale 1ns/1ps

// =====================================================================
// sticky flags, write-one-to-clear, set wins over clear
module pmev_sticky #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] stat,
  output logic hit
);

  logic [W-1:0] stat_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~clr) | set;
    end
  end

  assign stat = stat_r;
  assign hit = |(stat_r & mask);

endmodule

/* core/pmev_out_gate.sv */
`timescale 1ns/1ps

// =====================================================================
// output pin stage: hold-off gate and polarity
module pmev_out_gate (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  input wire logic hold,
  input wire logic pol,
  output logic pin
);

  logic pin_r;
  logic act;

  assign act = level & ~hold;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_r <= 1'b1;
    end else begin
      pin_r <= pol ? act : ~act;
    end
  end

  assign pin = pin_r;

endmodule

/* core/pmev_top.sv */
`timescale 1ns/1ps
`include "pmev_params.svh"

module pmev_top #(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmev_pkg::pmev_wake_t wake_evt,
  input wire logic clocks_ready,
  input wire logic stat_load,
  input wire logic [31:0] stat_word,
  input wire logic go_sleep,
  input wire logic energy_wake,
  input wire logic host_wake,
  output logic power_event_output,
  output logic power_low,
  output logic irq
);

  // ===================================================================
  // register state
  logic [15:0] idata_hi_r;
  pmev_pkg::pmev_ctrl_t ctrl_r;
  logic [3:0] int_mask_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  pmev_pkg::pmev_pstate_t pstate_r;
  pmev_pkg::pmev_pstate_t pstate_nxt;
  logic [3:0] wake_stat;
  logic [3:0] int_stat;
  logic wake_hit;
  logic int_hit;
  logic hold;

  // ===================================================================
  // bus decode
  logic setup;
  logic wr;
  logic [9:0] idx;

  assign setup = psel & ~penable & ~pready_r;
  assign wr = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign idx = paddr[11:2];

  function automatic logic is_idx(input logic [AW-1:0] a,
                                  input logic [9:0] i);
    is_idx = (a == AW'(`PMEV_ADDR(i)));
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    mapped = is_idx(a, `PMEV_IDX_IDATA_HI) |
             is_idx(a, `PMEV_IDX_PWR_CTRL) |
             is_idx(a, `PMEV_IDX_INT_STAT) |
             is_idx(a, `PMEV_IDX_INT_MASK);
  endfunction

  function automatic logic [15:0] ctrl_word(input pmev_pkg::pmev_ctrl_t c,
                                            input logic [3:0] st);
    logic [15:0] v;
    v = 16'h0000;
    v[`PMEV_BIT_DLY_EN] = c.dly_en;
    v[`PMEV_BIT_RSVD13] = c.rsvd13;
    v[`PMEV_BIT_POL] = c.pol;
    v[`PMEV_LSB_WOL_EN +: 4] = c.wol_en;
    v[`PMEV_BIT_AUTO_WAKE] = c.auto_wake;
    v[`PMEV_BIT_WAKE_NORM] = c.wake_norm;
    v[`PMEV_LSB_WAKE_STAT +: 4] = st;
    v[`PMEV_LSB_MODE +: 2] = c.mode;
    ctrl_word = v;
  endfunction

  // ===================================================================
  // bus answer: one wait-free access phase after setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      pready_r <= 1'b1;
      pslverr_r <= ~mapped(paddr);
      prdata_r <= 32'h0000_0000;
      if (!pwrite) begin
        if (is_idx(paddr, `PMEV_IDX_IDATA_HI)) begin
          prdata_r <= {16'h0000, idata_hi_r};
        end else if (is_idx(paddr, `PMEV_IDX_PWR_CTRL)) begin
          prdata_r <= {16'h0000, ctrl_word(ctrl_r, wake_stat)};
        end else if (is_idx(paddr, `PMEV_IDX_INT_STAT)) begin
          prdata_r <= {28'h0000000, int_stat};
        end else if (is_idx(paddr, `PMEV_IDX_INT_MASK)) begin
          prdata_r <= {28'h0000000, int_mask_r};
        end
      end
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ===================================================================
  // indirect data upper half
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset) begin
      idata_hi_r <= `PMEV_RST_IDATA_HI;
    end else if (stat_load) begin
      idata_hi_r <= stat_word[31:16];
    end else if (wr && is_idx(paddr, `PMEV_IDX_IDATA_HI)) begin
      idata_hi_r <= pwdata[15:0];
    end
  end

  // ===================================================================
  // power event control fields
  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset) begin
      ctrl_r.dly_en <= 1'b0;
      ctrl_r.rsvd13 <= 1'b0;
      ctrl_r.pol <= 1'b0;
      ctrl_r.wol_en <= `PMEV_RST_WOL_EN;
      ctrl_r.auto_wake <= 1'b0;
      ctrl_r.wake_norm <= 1'b0;
      ctrl_r.mode <= pmev_pkg::pmev_mode_t'(`PMEV_RST_MODE);
    end else if (wr && is_idx(paddr, `PMEV_IDX_PWR_CTRL)) begin
      ctrl_r.dly_en <= pwdata[`PMEV_BIT_DLY_EN];
      ctrl_r.rsvd13 <= pwdata[`PMEV_BIT_RSVD13];
      ctrl_r.pol <= pwdata[`PMEV_BIT_POL];
      ctrl_r.wol_en <= pwdata[`PMEV_LSB_WOL_EN +: 4];
      ctrl_r.auto_wake <= pwdata[`PMEV_BIT_AUTO_WAKE];
      ctrl_r.wake_norm <= pwdata[`PMEV_BIT_WAKE_NORM];
      ctrl_r.mode <= pmev_pkg::pmev_mode_t'(pwdata[`PMEV_LSB_MODE +: 2]);
    end
  end

  // ===================================================================
  // wake status: only power-up reset or a written one clears it
  logic [3:0] wake_clr;

  assign wake_clr = (wr && is_idx(paddr, `PMEV_IDX_PWR_CTRL)) ?
                    pwdata[`PMEV_LSB_WAKE_STAT +: 4] : 4'h0;

  // enable mask lines up frame, magic, link up, energy on 11..8
  pmev_sticky #(
    .W(4)
  ) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .set(wake_evt),
    .clr(wake_clr),
    .mask(ctrl_r.wol_en),
    .stat(wake_stat),
    .hit(wake_hit)
  );

  // ===================================================================
  // output pin
  assign hold = ctrl_r.dly_en & ctrl_r.auto_wake & ~clocks_ready;

  pmev_out_gate u_out (
    .clk(clk),
    .rst_n(rst_n),
    .level(wake_hit),
    .hold(hold),
    .pol(ctrl_r.pol),
    .pin(power_event_output)
  );

  // ===================================================================
  // interrupts
  logic [3:0] int_clr;

  assign int_clr = (wr && is_idx(paddr, `PMEV_IDX_INT_STAT)) ?
                   pwdata[3:0] : 4'h0;

  pmev_sticky #(
    .W(4)
  ) u_int (
    .clk(clk),
    .rst_n(rst_n),
    .set(wake_evt),
    .clr(int_clr),
    .mask(int_mask_r),
    .stat(int_stat),
    .hit(int_hit)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_mask_r <= `PMEV_RST_INT_MASK;
    end else if (wr && is_idx(paddr, `PMEV_IDX_INT_MASK)) begin
      int_mask_r <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= int_hit;
    end
  end

  // ===================================================================
  // power state
  always_comb begin
    pstate_nxt = pstate_r;
    case (pstate_r)
      pmev_pkg::PMEV_PS_NORMAL: begin
        if (ctrl_r.mode == pmev_pkg::PMEV_MODE_SOFT_PD) begin
          pstate_nxt = pmev_pkg::PMEV_PS_LOW;
        end else if (ctrl_r.mode == pmev_pkg::PMEV_MODE_ENERGY &&
                     go_sleep) begin
          pstate_nxt = pmev_pkg::PMEV_PS_LOW;
        end
      end
      pmev_pkg::PMEV_PS_LOW: begin
        if (ctrl_r.mode == pmev_pkg::PMEV_MODE_NORMAL || host_wake) begin
          pstate_nxt = pmev_pkg::PMEV_PS_NORMAL;
        end else if (ctrl_r.mode == pmev_pkg::PMEV_MODE_ENERGY &&
                     energy_wake && ctrl_r.auto_wake &&
                     ctrl_r.wake_norm) begin
          pstate_nxt = pmev_pkg::PMEV_PS_NORMAL;
        end
      end
      default: begin
        pstate_nxt = pmev_pkg::PMEV_PS_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || soft_reset) begin
      pstate_r <= pmev_pkg::PMEV_PS_NORMAL;
    end else begin
      pstate_r <= pstate_nxt;
    end
  end

  // ===================================================================
  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign power_low = pstate_r[1];

  // ===================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic act_now;
  assign act_now = |(wake_stat & ctrl_r.wol_en) & ~hold;

  property p_load_hi;
    stat_load |=> idata_hi_r == $past(stat_word[31:16]);
  endproperty
  a_load_hi: assert property (p_load_hi)
    else $error("upper half not loaded from counter word");

  property p_hold_off;
    ctrl_r.dly_en && ctrl_r.auto_wake && !clocks_ready && ctrl_r.pol
      |=> !power_event_output;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("output asserted before clocks ready");

  property p_no_delay;
    !ctrl_r.dly_en && |(wake_stat & ctrl_r.wol_en) && ctrl_r.pol
      |=> power_event_output;
  endproperty
  a_no_delay: assert property (p_no_delay)
    else $error("output delayed with delay disabled");

  property p_dly_ignored;
    !ctrl_r.auto_wake && |(wake_stat & ctrl_r.wol_en) && !ctrl_r.pol
      |=> !power_event_output;
  endproperty
  a_dly_ignored: assert property (p_dly_ignored)
    else $error("delay honoured without auto wake-up");

  property p_polarity;
    power_event_output == ($past(ctrl_r.pol) ? $past(act_now)
                                              : !$past(act_now));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("output level or polarity wrong");

  property p_frame_bit;
    wake_evt.frame && !ctrl_r.wol_en.frame && wake_stat == 4'h0
      |=> !wake_hit;
  endproperty
  a_frame_bit: assert property (p_frame_bit)
    else $error("disabled wake-up frame raised the output");

  property p_energy_hit;
    wake_evt.energy && ctrl_r.wol_en.energy
      && !(wr && is_idx(paddr, `PMEV_IDX_PWR_CTRL)) |=> wake_hit;
  endproperty
  a_energy_hit: assert property (p_energy_hit)
    else $error("enabled energy event not seen");

  property p_enable_reset;
    $rose(rst_n) |-> ctrl_r.wol_en == 4'h0;
  endproperty
  a_enable_reset: assert property (@(posedge clk) p_enable_reset)
    else $error("enables not zero after reset");

  property p_status_kept;
    soft_reset && wake_evt == 4'h0 && wake_clr == 4'h0
      |=> wake_stat == $past(wake_stat);
  endproperty
  a_status_kept: assert property (p_status_kept)
    else $error("soft reset disturbed wake status");

  property p_set_wins;
    wake_evt.link_up |=> wake_stat[1];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("link event lost against clear");

  property p_soft_pd;
    ctrl_r.mode == pmev_pkg::PMEV_MODE_SOFT_PD && !soft_reset
      ##1 ctrl_r.mode == pmev_pkg::PMEV_MODE_SOFT_PD && !soft_reset
      && !host_wake |=> power_low;
  endproperty
  a_soft_pd: assert property (p_soft_pd)
    else $error("soft power down did not enter low power");

  property p_auto_wake;
    pstate_r == pmev_pkg::PMEV_PS_LOW && energy_wake
      && !ctrl_r.auto_wake && !host_wake && !soft_reset
      && ctrl_r.mode == pmev_pkg::PMEV_MODE_ENERGY |=> power_low;
  endproperty
  a_auto_wake: assert property (p_auto_wake)
    else $error("woke without auto wake-up");

  property p_bus_answer;
    psel && !penable && !pready |=> pready ##1 !pready;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after setup");

  c_event_out: cover property (wake_hit ##1 power_event_output);
  c_held: cover property (hold && wake_hit ##[1:20] !hold);
  c_wake_up: cover property (power_low ##[1:50] !power_low);
  c_irq: cover property (irq ##[1:20] !irq);

endmodule

/* tb/pmev_pwr_model.sv */
`timescale 1ns/1ps

// =====================================================================
// power controller side: event pulses, readiness, counter words
module pmev_pwr_model (
  input wire logic clk,
  output pmev_pkg::pmev_wake_t wake_evt,
  output logic clocks_ready,
  output logic stat_load,
  output logic [31:0] stat_word,
  output logic go_sleep,
  output logic energy_wake,
  output logic host_wake
);
  initial begin
    wake_evt <= '0;
    clocks_ready <= 1'b1;
    stat_load <= 1'b0;
    stat_word <= 32'h0000_0000;
    go_sleep <= 1'b0;
    energy_wake <= 1'b0;
    host_wake <= 1'b0;
  end

  // one-cycle pulse: bits 3..0 wake events, 4 sleep, 5 energy, 6 host
  task automatic pulse(input logic [6:0] sel);
    @(posedge clk);
    {host_wake, energy_wake, go_sleep, wake_evt} <= sel;
    @(posedge clk);
    {host_wake, energy_wake, go_sleep, wake_evt} <= 7'h00;
  endtask

  task automatic load(input logic [31:0] w);
    @(posedge clk);
    stat_word <= w;
    stat_load <= 1'b1;
    @(posedge clk);
    stat_load <= 1'b0;
    stat_word <= ~w; // stale word is not held
  endtask

  task automatic ready(input logic v);
    @(posedge clk);
    clocks_ready <= v;
  endtask
endmodule

/* tb/pmev_top_tb.sv */
`timescale 1ns/1ps

module pmev_top_tb;
  localparam logic [11:0] A_IHI = 12'h348;
  localparam logic [11:0] A_CTRL = 12'h350;
  localparam logic [11:0] A_STAT = 12'h380;
  localparam logic [11:0] A_MASK = 12'h384;
  localparam logic [31:0] POL = 32'h1000;
  localparam logic [31:0] DLY = 32'h4000;
  localparam logic [31:0] AUTO = 32'h80;
  logic clk;
  logic rst_n;
  logic soft_reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pmev_pkg::pmev_wake_t wake_evt;
  logic clocks_ready, stat_load, go_sleep, energy_wake, host_wake;
  logic [31:0] stat_word;
  logic pout, power_low, irq;
  logic [31:0] q;
  logic e;
  int num_errors = 0;
  int checks = 0;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  pmev_top #(.AW(12)) u_pmev_top (.clk(clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_evt(wake_evt),
    .clocks_ready(clocks_ready), .stat_load(stat_load),
    .stat_word(stat_word), .go_sleep(go_sleep),
    .energy_wake(energy_wake), .host_wake(host_wake),
    .power_event_output(pout), .power_low(power_low), .irq(irq));

  pmev_pwr_model u_pmev_pwr_model (.clk(clk), .wake_evt(wake_evt),
    .clocks_ready(clocks_ready), .stat_load(stat_load),
    .stat_word(stat_word), .go_sleep(go_sleep),
    .energy_wake(energy_wake), .host_wake(host_wake));

  task automatic summarize();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer, waits for pready at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1, "pready timeout");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp, "read data");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic done(input string t);
    $display("test %s finished at %0t", t, $time);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    rst_n <= 1'b0;
    soft_reset <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // ==================================================================
    // reset values and field access
    rd(A_CTRL, 32'h0);
    rd(A_IHI, 32'h0);
    chk(pout, 1'b1, "idle pin active low");
    chk(irq, 1'b0, "irq after reset");
    wr(A_CTRL, 32'hF00);
    rd(A_CTRL, 32'hF00);
    u_pmev_pwr_model.load(32'hA5C3_1234);
    rd(A_IHI, 32'hA5C3);
    wr(A_IHI, 32'h1357);
    rd(A_IHI, 32'h1357);
    apb(1'b0, 12'h100, 32'h0);
    chk(e, 1'b1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    done("registers");
    // ==================================================================
    // each event against its own enable bit
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, POL);
      u_pmev_pwr_model.pulse(7'(1 << i));
      cyc(3);
      chk(pout, 1'b0, "disabled event drove pin");
      rd(A_CTRL, POL | (32'h4 << i));
      wr(A_CTRL, POL | (32'h4 << i));
      wr(A_CTRL, POL | (32'h100 << i));
      u_pmev_pwr_model.pulse(7'(1 << i));
      cyc(3);
      chk(pout, 1'b1, "enabled event");
      wr(A_CTRL, POL | (32'h100 << i) | (32'h4 << i));
      cyc(3);
      chk(pout, 1'b0, "pin after status clear");
    end
    done("enables");
    // ==================================================================
    // interrupt raise, clear and mask
    wr(A_STAT, 32'hF);
    wr(A_MASK, 32'h1);
    u_pmev_pwr_model.pulse(7'h01);
    cyc(3);
    chk(irq, 1'b1, "irq raised");
    wr(A_STAT, 32'h1);
    cyc(3);
    chk(irq, 1'b0, "irq cleared");
    wr(A_MASK, 32'h0);
    u_pmev_pwr_model.pulse(7'h01);
    cyc(3);
    chk(irq, 1'b0, "irq masked");
    rd(A_STAT, 32'h1);
    done("interrupt");
    // ==================================================================
    // hold-off and polarity
    wr(A_CTRL, 32'h3C);
    u_pmev_pwr_model.ready(1'b0);
    wr(A_CTRL, POL | DLY | AUTO | 32'h100);
    u_pmev_pwr_model.pulse(7'h01);
    cyc(3);
    chk(pout, 1'b0, "held off");
    u_pmev_pwr_model.ready(1'b1);
    cyc(3);
    chk(pout, 1'b1, "released after ready");
    wr(A_CTRL, 32'h3C);
    u_pmev_pwr_model.ready(1'b0);
    wr(A_CTRL, POL | DLY | 32'h100);
    u_pmev_pwr_model.pulse(7'h01);
    cyc(3);
    chk(pout, 1'b1, "delay ignored");
    u_pmev_pwr_model.ready(1'b1);
    wr(A_CTRL, 32'h3C);
    wr(A_CTRL, 32'h100);
    u_pmev_pwr_model.pulse(7'h01);
    cyc(3);
    chk(pout, 1'b0, "active low asserted");
    wr(A_CTRL, 32'h13C);
    cyc(3);
    chk(pout, 1'b1, "active low released");
    done("pin");
    // ==================================================================
    // power modes and soft reset
    wr(A_CTRL, 32'hC1);
    rd(A_CTRL, 32'hC1);
    u_pmev_pwr_model.pulse(7'h10);
    cyc(3);
    chk(power_low, 1'b1, "energy mode sleep");
    u_pmev_pwr_model.pulse(7'h20);
    cyc(3);
    chk(power_low, 1'b0, "auto wake");
    wr(A_CTRL, 32'h2);
    cyc(3);
    chk(power_low, 1'b1, "soft power down");
    wr(A_CTRL, 32'h0);
    u_pmev_pwr_model.pulse(7'h40);
    cyc(3);
    chk(power_low, 1'b0, "host wake");
    wr(A_CTRL, 32'h1100);
    u_pmev_pwr_model.pulse(7'h01);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rd(A_CTRL, 32'h4);
    wr(A_CTRL, 32'h3C);
    rd(A_CTRL, 32'h0);
    done("power");
    summarize();
  end
endmodule
